/* File: logic/fprl_map.svh */
`ifndef FPRL_MAP_SVH
`define FPRL_MAP_SVH

// Register indices; the byte address on the bus is four times the index.
`define FPRL_IDX_ACOUSTIC   8'h62
`define FPRL_IDX_CTRL       8'h70
`define FPRL_IDX_FAN_BASE   8'h71

// Field positions of the rate control register.
`define FPRL_LOCAL_RATE_LSB 0
`define FPRL_LOCAL_RATE_MSB 2
`define FPRL_SMOOTH_BIT     3
`define FPRL_REM2_RATE_LSB  4
`define FPRL_REM2_RATE_MSB  6
`define FPRL_ACOUSTIC_RESET 8'h00

// Field positions of the control register.
`define FPRL_CTRL_LOCK_BIT    0
`define FPRL_CTRL_STRETCH_BIT 1

// Field positions of each fan register.
`define FPRL_FAN_TARGET_LSB 0
`define FPRL_FAN_TARGET_MSB 7
`define FPRL_FAN_SRC_LSB    8
`define FPRL_FAN_SRC_MSB    9
`define FPRL_FAN_DUTY_LSB   16
`define FPRL_FAN_DUTY_MSB   23

// Timing: full-scale ramp times at code 000, and the clock rate.
`define FPRL_RAMP_FULL_MS       37500
`define FPRL_RAMP_FULL_SLOW_MS  52200
`define FPRL_CLK_KHZ            100000
`define FPRL_DUTY_STEPS         255
`define FPRL_DUTY_FULL          8'hff

`endif

/* File: logic/fprl_pkg.sv */
`default_nettype none
package fprl_pkg;

  // Which temperature channel governs a fan output.
  typedef enum logic [1:0] {
    SRC_DIRECT  = 2'h0,
    SRC_LOCAL   = 2'h1,
    SRC_REMOTE2 = 2'h2
  } fprl_src_t;

  typedef logic [7:0] fprl_duty_t;

endpackage
`default_nettype wire

/* File: logic/fprl_top.sv */
// Summary of operation
// [R1] Acoustic bits 2:0 set local ramp rate.
// [R2] Duty steps toward new target, not jump.
// [R3] Codes give 1,2,3,4,8,12,24,48 per slot.
// [R4] Full ramp times; config bit stretches them.
// [R5] Acoustic bit 3 enables local smoothing.
// [R6] Acoustic bits 6:4 set Remote 2 rate.
// [R7] Lock bit makes acoustic register read-only.
// [R8] Acoustic register resets to all zeros.
// [R9] Acoustic bit 7 is plain storage only.
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "fprl_map.svh"

// Programming model.
// The block sits behind a small register file on the peripheral bus.
// Every register takes one aligned 32-bit word. The byte address of a
// register is four times its index, so the bus address is compared with
// the index shifted up by two bits. Bits that a register does not store
// read back as zero and are dropped on a write.
//
// Rate control register.
// Bits 2:0 hold the rate code for fans governed by the local channel.
// Bit 3 turns smoothing on for the local channel. With it clear, a fan
// under local control follows its target at once.
// Bits 6:4 hold the rate code for fans governed by the Remote 2 channel.
// Remote 2 has no enable of its own here, so those fans always ramp.
// Bit 7 is plain storage. It reads back what was written and has no
// effect on ramping, so software may use it as a scratch bit.
// The register comes out of reset as all zeros, which selects the
// slowest code on both channels and leaves local smoothing off.
//
// Control register.
// Bit 0 is the lock. Once set it stays set until the next reset, and
// from then on every write to the rate control register is dropped.
// The drop is silent: the bus still completes without an error, so a
// driver that retries after a locked write will not hang.
// Bit 1 stretches every slot, which lengthens every ramp by the same
// factor. It stays writable under lock, because only the rate control
// register is frozen.
//
// Fan registers, one for each fan output.
// Bits 7:0 hold the target duty that the control loop asks for.
// Bits 9:8 name the channel that governs the fan: zero and three mean
// direct control, one means local, two means Remote 2.
// Bits 23:16 show the current ramped duty and are read-only.
//
// Ramping.
// A shared slot timer raises a one-cycle tick once every slot. At each
// tick a ramped fan moves its duty toward the target by the increment
// that its rate code selects, and never past the target. Between ticks
// the duty holds. The full-scale ramp time is therefore about the slot
// length times the number of steps needed to cover the whole range.
// The last step is clipped to the target, so large increments finish a
// little early or late against the nominal time; this was traded for a
// single slot timer shared by every fan.
// A change of rate code takes effect at the next tick. A change of the
// stretch bit takes effect in the slot under way, since the timer compares
// against the selected length on every clock.
//
// Drive pins.
// Each fan pin is a plain PWM output with a 256-clock period. The pin is
// high while the shared period counter is below the duty, and full duty
// holds the pin high for the whole period so that the fan never sees a
// one-clock gap at full speed.
//
// Bus timing.
// The slave inserts one wait state: ready rises one clock into the access
// phase and stays high for one clock. Read data and the error flag are
// captured as ready rises, so both come straight from flip-flops.
// An unmapped address answers with the error flag and zero read data,
// and a write to it changes nothing.
//
// Limitations.
// The block does not measure temperature and does not run the fan curve.
// It only limits how fast the duty moves toward a target set by software.

module fprl_top #(
  parameter int          NUM_FANS        = 3,
  parameter int          ADDR_W          = 12,
  parameter logic [31:0] SLOT_CYCLES     = 32'((64'(`FPRL_RAMP_FULL_MS)
                                           * 64'(`FPRL_CLK_KHZ))
                                           / 64'(`FPRL_DUTY_STEPS)),
  parameter logic [31:0] SLOT_CYCLES_SLOW = 32'((64'(`FPRL_RAMP_FULL_SLOW_MS)
                                           * 64'(`FPRL_CLK_KHZ))
                                           / 64'(`FPRL_DUTY_STEPS))
) (
  input  wire logic                  clk_sys,
  input  wire logic                  reset,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [ADDR_W-1:0]     paddr,
  input  wire logic [31:0]           pwdata,
  output var  logic [31:0]           prdata,
  output var  logic                  pready,
  output var  logic                  pslverr,
  output var  logic [NUM_FANS-1:0]   fanDriveOutput,
  output var  logic [8*NUM_FANS-1:0] fanDutyLevel
);

  logic [7:0]          acoustic_r;
  logic                lock_r;
  logic                stretch_r;
  logic [31:0]         slotCnt_r;
  logic                slotTick_r;
  logic [7:0]          pwmCnt_r;
  fprl_pkg::fprl_duty_t target_r [NUM_FANS];
  fprl_pkg::fprl_src_t  src_r    [NUM_FANS];
  fprl_pkg::fprl_duty_t duty_r   [NUM_FANS];
  logic                accessEnd;
  logic                wrEn;

  // True when the bus address selects the register at the given index.
  function automatic logic addrIs(input logic [ADDR_W-1:0] a,
                                  input logic [7:0]        idx);
    addrIs = (a == ADDR_W'({idx, 2'b00}));
  endfunction

  // Duty increment applied per slot for a rate code.
  function automatic logic [7:0] rateStep(input logic [2:0] code);
    case (code)
      3'h0:    rateStep = 8'h01; // R3
      3'h1:    rateStep = 8'h02;
      3'h2:    rateStep = 8'h03;
      3'h3:    rateStep = 8'h04;
      3'h4:    rateStep = 8'h08;
      3'h5:    rateStep = 8'h0c;
      3'h6:    rateStep = 8'h18;
      default: rateStep = 8'h30;
    endcase
  endfunction

  // One step from cur toward tgt, never overshooting the target.
  function automatic logic [7:0] stepToward(input logic [7:0] cur,
                                            input logic [7:0] tgt,
                                            input logic [7:0] inc);
    if (tgt > cur) begin
      stepToward = (tgt - cur > inc) ? cur + inc : tgt;
    end else begin
      stepToward = (cur - tgt > inc) ? cur - inc : tgt;
    end
  endfunction

  // The slave answers on the second access cycle, so one wait state.
  assign accessEnd = psel & penable & pready;
  assign wrEn      = accessEnd & pwrite;

  // Ready rises one cycle into the access phase and drops after the handshake.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pready <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
    end
  end

  // Read data and error are captured as ready rises, so both come from flops.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else if (psel & penable & ~pready) begin
      prdata  <= 32'h0;
      pslverr <= 1'b1;
      if (addrIs(paddr, `FPRL_IDX_ACOUSTIC)) begin
        prdata  <= {24'h0, acoustic_r};
        pslverr <= 1'b0;
      end
      if (addrIs(paddr, `FPRL_IDX_CTRL)) begin
        prdata[`FPRL_CTRL_LOCK_BIT]    <= lock_r;
        prdata[`FPRL_CTRL_STRETCH_BIT] <= stretch_r;
        pslverr                        <= 1'b0;
      end
      for (int i = 0; i < NUM_FANS; i++) begin
        if (addrIs(paddr, 8'(`FPRL_IDX_FAN_BASE + i))) begin
          prdata[`FPRL_FAN_TARGET_MSB:`FPRL_FAN_TARGET_LSB] <= target_r[i];
          prdata[`FPRL_FAN_SRC_MSB:`FPRL_FAN_SRC_LSB]       <= src_r[i];
          prdata[`FPRL_FAN_DUTY_MSB:`FPRL_FAN_DUTY_LSB]     <= duty_r[i];
          pslverr                                           <= 1'b0;
        end
      end
    end else begin
      pslverr <= 1'b0;
    end
  end

  // Rate control register; a write under lock is dropped without an error.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      acoustic_r <= `FPRL_ACOUSTIC_RESET; // R8
    end else if (wrEn && addrIs(paddr, `FPRL_IDX_ACOUSTIC) && !lock_r) begin
      acoustic_r <= pwdata[7:0]; // R7 R9
    end
  end

  // Lock can only be set; only a reset opens the register again.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      lock_r    <= 1'b0;
      stretch_r <= 1'b0;
    end else if (wrEn && addrIs(paddr, `FPRL_IDX_CTRL)) begin
      lock_r    <= lock_r | pwdata[`FPRL_CTRL_LOCK_BIT]; // R7
      stretch_r <= pwdata[`FPRL_CTRL_STRETCH_BIT];
    end
  end

  // Slot timer; the stretch bit selects the longer slot for every code.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      slotCnt_r  <= 32'h0;
      slotTick_r <= 1'b0;
    end else begin
      slotTick_r <= 1'b0;
      if (slotCnt_r >= (stretch_r ? SLOT_CYCLES_SLOW : SLOT_CYCLES) - 32'h1)
      begin
        slotCnt_r  <= 32'h0; // R4
        slotTick_r <= 1'b1;
      end else begin
        slotCnt_r <= slotCnt_r + 32'h1;
      end
    end
  end

  // Free-running PWM period counter shared by all fan outputs.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pwmCnt_r <= 8'h00;
    end else begin
      pwmCnt_r <= pwmCnt_r + 8'h01;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_FANS; g++) begin : gFan
      // Fan target and governing channel, as set by the control loop.
      always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
          target_r[g] <= 8'h00;
          src_r[g]    <= fprl_pkg::SRC_DIRECT;
        end else if (wrEn && addrIs(paddr, 8'(`FPRL_IDX_FAN_BASE + g))) begin
          target_r[g] <= pwdata[`FPRL_FAN_TARGET_MSB:`FPRL_FAN_TARGET_LSB];
          src_r[g]    <= fprl_pkg::fprl_src_t'(
                           pwdata[`FPRL_FAN_SRC_MSB:`FPRL_FAN_SRC_LSB]);
        end
      end

      // Ramped duty; a channel without smoothing follows its target at once.
      always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
          duty_r[g] <= 8'h00;
        end else begin
          case (src_r[g])
            fprl_pkg::SRC_LOCAL: begin
              if (!acoustic_r[`FPRL_SMOOTH_BIT]) begin
                duty_r[g] <= target_r[g]; // R5
              end else if (slotTick_r) begin
                duty_r[g] <= stepToward(duty_r[g], target_r[g], // R1 R2
                  rateStep(acoustic_r[`FPRL_LOCAL_RATE_MSB:
                                      `FPRL_LOCAL_RATE_LSB]));
              end
            end
            fprl_pkg::SRC_REMOTE2: begin
              if (slotTick_r) begin
                duty_r[g] <= stepToward(duty_r[g], target_r[g], // R6 R2
                  rateStep(acoustic_r[`FPRL_REM2_RATE_MSB:
                                      `FPRL_REM2_RATE_LSB]));
              end
            end
            default: begin
              duty_r[g] <= target_r[g];
            end
          endcase
        end
      end

      // Registered drive pin and duty report; full scale holds the pin high.
      always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
          fanDriveOutput[g]     <= 1'b0;
          fanDutyLevel[8*g +: 8] <= 8'h00;
        end else begin
          fanDriveOutput[g]     <= (duty_r[g] == `FPRL_DUTY_FULL) ||
                                   (pwmCnt_r < duty_r[g]);
          fanDutyLevel[8*g +: 8] <= duty_r[g];
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

/* File: tb/fan_pwm_ramp_rate_limiter_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module fan_pwm_ramp_rate_limiter_tb;
  localparam int INC [8] = '{1, 2, 3, 4, 8, 12, 24, 48};
  logic        clk_sys = 1'b0, reset = 1'b1, psel = 1'b0;
  logic        penable = 1'b0, pwrite = 1'b0, pready, pslverr, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [2:0]  fanDriveOutput;
  logic [23:0] fanDutyLevel;
  logic [8:0]  highCnt;
  int          fails = 0, n_checks = 0;
  // Clock at 100 MHz.
  always #5 clk_sys = ~clk_sys;
  // Short slots of 4 and 6 clocks keep each ramp step within a few clocks.
  fprl_top #(.SLOT_CYCLES(32'd4), .SLOT_CYCLES_SLOW(32'd6)) i_dut (
    .clk_sys, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .fanDriveOutput, .fanDutyLevel);
  fprl_fan_model i_fan (.clk_sys, .reset, .pin(fanDriveOutput[0]), .highCnt);
  task automatic wrap_up();
    if (fails == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic tmo();
    fails++;
    wrap_up();
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // One APB transfer; the request stands until pready is seen high.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_sys);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) tmo();
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wchg(input int f, input logic [7:0] d0, output int n);
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (fanDutyLevel[8*f+:8] === d0 && n < 200);
    if (n >= 200) tmo();
  endtask
  // Restart fan f from zero, then check the first two steps and their gap.
  task automatic t_ramp(input int f, input int inc, input int slot);
    int n;
    logic [11:0] a;
    a = 12'h1c4 + 12'(4 * f);
    apb(1'b1, a, 32'h0);
    repeat (3) @(posedge clk_sys);
    apb(1'b1, a, 32'h0ff | (32'(f + 1) << 8));
    wchg(f, 8'h00, n);
    chk(fanDutyLevel[8*f+:8], inc);
    wchg(f, fanDutyLevel[8*f+:8], n);
    chk(n, slot);
    chk(fanDutyLevel[8*f+:8], (2 * inc > 255) ? 255 : 2 * inc);
  endtask
  task automatic t_regs();
    apb(1'b0, 12'h188, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, 12'h188, 32'hff);
    apb(1'b0, 12'h188, 32'h0);
    chk(rd, 32'hff);
    apb(1'b0, 12'h004, 32'h0);
    chk(32'(er), 32'h1);
  endtask
  // Without smoothing the local fan jumps, and the fan feels it.
  task automatic t_jump();
    apb(1'b1, 12'h188, 32'h0);
    apb(1'b1, 12'h1c4, 32'h180);
    repeat (3) @(posedge clk_sys);
    chk(fanDutyLevel[7:0], 8'h80);
    repeat (520) @(posedge clk_sys);
    chk(highCnt, 9'h080);
    apb(1'b1, 12'h1c4, 32'h1ff);
    repeat (520) @(posedge clk_sys);
    chk(highCnt, 9'h100);
    // Fan 1 finished its Remote 2 ramp long ago and must sit at full.
    chk(fanDutyLevel[15:8], 8'hff);
    chk(fanDriveOutput[1], 1'b1);
    // Fan 2 under direct control jumps, and its pin follows.
    apb(1'b1, 12'h1cc, 32'h0ff);
    repeat (3) @(posedge clk_sys);
    chk(fanDutyLevel[23:16], 8'hff);
    chk(fanDriveOutput[2], 1'b1);
  endtask
  task automatic t_lock();
    apb(1'b1, 12'h188, 32'h5a);
    apb(1'b1, 12'h1c0, 32'h1);
    apb(1'b1, 12'h188, 32'h25);
    apb(1'b0, 12'h188, 32'h0);
    chk(rd, 32'h5a);
    chk(32'(er), 32'h0);
  endtask
  // Code c in both rate fields, smoothing on: c * 17 + 8 packs them.
  initial begin
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    t_regs();
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, 12'h188, 32'(c * 17 + 8));
      t_ramp(0, INC[c], 4);
      t_ramp(1, INC[c], 4);
    end
    apb(1'b1, 12'h1c0, 32'h2);
    t_ramp(0, 48, 6);
    t_jump();
    t_lock();
    wrap_up();
  end
endmodule
`default_nettype wire

/* File: tb/fprl_fan_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fprl_fan_model (
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic       pin,
  output var  logic [8:0] highCnt
);
  logic [7:0] phase_r;
  logic [8:0] acc_r;
  // A fan only feels the mean drive, so count high clocks per 256 window.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      phase_r <= 8'h00;
      acc_r   <= 9'h000;
      highCnt <= 9'h000;
    end else begin
      phase_r <= phase_r + 8'h01;
      acc_r   <= (phase_r == 8'hff) ? 9'h000 : acc_r + 9'(pin);
      if (phase_r == 8'hff) highCnt <= acc_r + 9'(pin);
    end
  end
endmodule
`default_nettype wire

/* File: tb/fprl_top_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module fprl_top_sva (
  input wire logic        clk_sys,
  input wire logic        reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [2:0]  fanDriveOutput,
  input wire logic [23:0] fanDutyLevel
);
  wire [7:0] d0 = fanDutyLevel[7:0];
  wire [7:0] d1 = fanDutyLevel[15:8];
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // Fan 1 only ever climbs under Remote 2 control, never faster than 48.
  a_rem2_step: assert property ($past(d1) <= d1 |->
    d1 - $past(d1) <= 8'd48)
    else $error("remote 2 step too large");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held");
  a_ready_wait: assert property ($rose(penable) && psel |=> pready)
    else $error("pready late");
  a_ready_cause: assert property (pready |-> psel && penable)
    else $error("pready without access");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_err_rdata: assert property (pslverr |-> prdata == 32'h0)
    else $error("error read not zero");
  a_full_high: assert property ((d0 == 8'hff) [*2] |->
    fanDriveOutput[0])
    else $error("full duty pin low");
  a_zero_low: assert property ((d0 == 8'h00) [*2] |->
    !fanDriveOutput[0])
    else $error("zero duty pin high");
endmodule
bind fprl_top fprl_top_sva i_sva (.clk_sys, .reset, .psel, .penable,
  .prdata, .pready, .pslverr, .fanDriveOutput, .fanDutyLevel);
`default_nettype wire
